/* shared/stk_defines.svh */
// Register offsets, field positions and reset values of the tick down-counter
`ifndef STK_DEFINES_SVH
`define STK_DEFINES_SVH
`define STK_ADDR_W        4
`define STK_OFF_CTRL      4'h0
`define STK_OFF_RELOAD    4'h4
`define STK_OFF_CURRENT   4'h8
`define STK_OFF_IRQ_STAT  4'hc
`define STK_OFF_IRQ_MASK  4'hc
`define STK_CTRL_EN_BIT   0
`define STK_CTRL_TICKIE_BIT 1
`define STK_CTRL_FLAG_BIT 16
`define STK_CNT_W         24
`define STK_CTRL_RST      2'h0
`define STK_RELOAD_RST    24'h000000
`define STK_MASK_RST      1'h0
`endif

/* shared/stk_pkg.sv */
// Types shared by the tick down-counter
package stk_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } stk_bus_req_t;
endpackage

/* src/stk_timer.sv */
// Tick down-counter with a plain register port and a masked interrupt
`timescale 1ns/1ns
`include "stk_defines.svh"
module stk_timer (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire stk_pkg::stk_bus_req_t bus_i,
  output logic [31:0]               rdata_o,
  output logic                      tick_req_o,
  output logic                      irq_o
);
  import stk_pkg::*;

  logic [`STK_CNT_W-1:0] cnt_q;
  logic [`STK_CNT_W-1:0] cnt_d;
  logic [`STK_CNT_W-1:0] reload_q;
  logic [1:0]            ctrl_q;
  logic                  flag_q;
  logic                  flag_d;
  logic                  stat_q;
  logic                  mask_q;
  logic                  tick_q;
  logic [31:0]           rdata_q;

  // Register select, shared by every decoded offset
  function automatic logic reg_hit(input logic [3:0] a,
                                   input logic [3:0] off);
    return a == off;
  endfunction

  wire sel_ctrl = reg_hit(bus_i.addr, `STK_OFF_CTRL);
  wire sel_rel  = reg_hit(bus_i.addr, `STK_OFF_RELOAD);
  wire sel_cur  = reg_hit(bus_i.addr, `STK_OFF_CURRENT);
  wire sel_stat = reg_hit(bus_i.addr, `STK_OFF_IRQ_STAT);
  wire sel_any  = sel_ctrl || sel_rel || sel_cur || sel_stat;
  wire en       = ctrl_q[`STK_CTRL_EN_BIT];
  wire stopped  = reload_q == `STK_RELOAD_RST;
  wire running  = en && !stopped;
  wire wr_cur   = bus_i.wr && sel_cur;
  // Zero reached on a decrement from one; a clearing write is no decrement
  wire hit_zero = running && !wr_cur && cnt_q == 24'h000001;

  // Count step per clock, wrap through reload
  assign cnt_d = stopped ? 24'h000000 :
                 wr_cur ? 24'h000000 :
                 !en ? cnt_q :
                 (cnt_q == 24'h000000) ? reload_q :
                 cnt_q - 24'h000001;
  // Set beats the read-clear
  assign flag_d = hit_zero ? 1'b1 : ((bus_i.rd && sel_ctrl) ? 1'b0 : flag_q);

  wire [31:0] rd_mux = sel_ctrl ? {15'h0000, flag_q, 14'h0000, ctrl_q} :
                       sel_rel  ? {8'h00, reload_q} :
                       sel_cur  ? {8'h00, cnt_q} :
                       sel_stat ? {30'h00000000, mask_q, stat_q} : 32'h00000000;

  // Count left without reset: it is forced to zero while the reload value is zero
  always_ff @(posedge clock_i) begin
    cnt_q <= cnt_d;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reload_q <= `STK_RELOAD_RST;
      ctrl_q   <= `STK_CTRL_RST;
      flag_q   <= 1'b0;
      stat_q   <= 1'b0;
      mask_q   <= `STK_MASK_RST;
      tick_q   <= 1'b0;
      rdata_q  <= 32'h00000000;
    end else begin
      if (bus_i.wr && sel_rel) begin
        reload_q <= bus_i.wdata[`STK_CNT_W-1:0];
      end
      if (bus_i.wr && sel_ctrl) begin
        ctrl_q <= bus_i.wdata[1:0];
      end
      if (bus_i.wr && sel_stat) begin
        mask_q <= bus_i.wdata[1];
      end
      flag_q  <= flag_d;
      // Write one clears; a new event in the same cycle wins
      stat_q  <= hit_zero || (stat_q && !(bus_i.wr && sel_stat && bus_i.wdata[0]));
      tick_q  <= hit_zero && ctrl_q[`STK_CTRL_TICKIE_BIT];
      rdata_q <= bus_i.rd ? rd_mux : 32'h00000000;
    end
  end

  assign rdata_o    = rdata_q;
  assign tick_req_o = tick_q;
  assign irq_o      = stat_q && mask_q;

  property p_flag_set;
    @(posedge clock_i) disable iff (rst_i) hit_zero |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set at zero");
  property p_flag_rdclr;
    @(posedge clock_i) disable iff (rst_i) (bus_i.rd && sel_ctrl && !hit_zero) |=> !flag_q;
  endproperty
  a_flag_rdclr: assert property (p_flag_rdclr) else $error("flag not cleared by read");
  property p_wr_clear;
    @(posedge clock_i) disable iff (rst_i) wr_cur |=> cnt_q == 24'h000000;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("write did not clear count");
  property p_stop;
    @(posedge clock_i) disable iff (rst_i) stopped |=> cnt_q == 24'h000000;
  endproperty
  a_stop: assert property (p_stop) else $error("count moved with zero reload");
  property p_reload;
    @(posedge clock_i) disable iff (rst_i)
      (running && !wr_cur && cnt_q == 24'h000000) |=> cnt_q == $past(reload_q);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at zero");
  property p_dec;
    @(posedge clock_i) disable iff (rst_i)
      (running && !wr_cur && cnt_q != 24'h000000) |=> cnt_q == $past(cnt_q) - 24'h000001;
  endproperty
  a_dec: assert property (p_dec) else $error("count did not step down");
  property p_hold;
    @(posedge clock_i) disable iff (rst_i) (!en && !stopped && !wr_cur) |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while disabled");
  property p_tick;
    @(posedge clock_i) disable iff (rst_i) hit_zero |=> tick_req_o == $past(ctrl_q[1]);
  endproperty
  a_tick: assert property (p_tick) else $error("tick request wrong");
  property p_irq;
    @(posedge clock_i) disable iff (rst_i) (hit_zero && mask_q) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  // Read port: data stand one cycle after the strobe, zero otherwise
  property p_rdata_idle;
    @(posedge clock_i) disable iff (rst_i)
      !bus_i.rd |=> rdata_o == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");

  property p_rd_ctrl;
    @(posedge clock_i) disable iff (rst_i)
      (bus_i.rd && sel_ctrl) |=> rdata_o == {15'h0000, $past(flag_q), 14'h0000, $past(ctrl_q)};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

  property p_rd_rel;
    @(posedge clock_i) disable iff (rst_i)
      (bus_i.rd && sel_rel) |=> rdata_o == {8'h00, $past(reload_q)};
  endproperty
  a_rd_rel: assert property (p_rd_rel) else $error("reload read wrong");

  property p_rd_cur;
    @(posedge clock_i) disable iff (rst_i)
      (bus_i.rd && sel_cur) |=> rdata_o == {8'h00, $past(cnt_q)};
  endproperty
  a_rd_cur: assert property (p_rd_cur) else $error("count read wrong");

  property p_rd_stat;
    @(posedge clock_i) disable iff (rst_i)
      (bus_i.rd && sel_stat) |=> rdata_o == {30'h00000000, $past(mask_q), $past(stat_q)};
  endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("interrupt read wrong");

  property p_rd_unmapped;
    @(posedge clock_i) disable iff (rst_i)
      (bus_i.rd && !sel_any) |=> rdata_o == 32'h00000000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  // Register writes land at the next edge and nothing else moves them
  property p_rel_wr;
    @(posedge clock_i) disable iff (rst_i)
      (bus_i.wr && sel_rel) |=> reload_q == $past(bus_i.wdata[`STK_CNT_W-1:0]);
  endproperty
  a_rel_wr: assert property (p_rel_wr) else $error("reload write lost");

  property p_rel_keep;
    @(posedge clock_i) disable iff (rst_i)
      !(bus_i.wr && sel_rel) |=> $stable(reload_q);
  endproperty
  a_rel_keep: assert property (p_rel_keep) else $error("reload moved without write");

  property p_ctrl_wr;
    @(posedge clock_i) disable iff (rst_i)
      (bus_i.wr && sel_ctrl) |=> ctrl_q == $past(bus_i.wdata[1:0]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  property p_ctrl_keep;
    @(posedge clock_i) disable iff (rst_i)
      !(bus_i.wr && sel_ctrl) |=> $stable(ctrl_q);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("control moved without write");

  property p_mask_wr;
    @(posedge clock_i) disable iff (rst_i)
      (bus_i.wr && sel_stat) |=> mask_q == $past(bus_i.wdata[1]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  property p_mask_keep;
    @(posedge clock_i) disable iff (rst_i)
      !(bus_i.wr && sel_stat) |=> $stable(mask_q);
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("mask moved without write");

  // Sticky status and flag: set wins, clears only by their own access
  property p_stat_set;
    @(posedge clock_i) disable iff (rst_i)
      hit_zero |=> stat_q;
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("status not set at zero");

  property p_stat_w1c;
    @(posedge clock_i) disable iff (rst_i)
      (bus_i.wr && sel_stat && bus_i.wdata[0] && !hit_zero) |=> !stat_q;
  endproperty
  a_stat_w1c: assert property (p_stat_w1c) else $error("status not cleared by write one");

  property p_stat_w0;
    @(posedge clock_i) disable iff (rst_i)
      (stat_q && !(bus_i.wr && sel_stat && bus_i.wdata[0])) |=> stat_q;
  endproperty
  a_stat_w0: assert property (p_stat_w0) else $error("status lost without write one");

  property p_stat_quiet;
    @(posedge clock_i) disable iff (rst_i)
      (!stat_q && !hit_zero) |=> !stat_q;
  endproperty
  a_stat_quiet: assert property (p_stat_quiet) else $error("status set without event");

  property p_flag_quiet;
    @(posedge clock_i) disable iff (rst_i)
      (!flag_q && !hit_zero) |=> !flag_q;
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("flag set without event");

  property p_flag_hold;
    @(posedge clock_i) disable iff (rst_i)
      (flag_q && !(bus_i.rd && sel_ctrl)) |=> flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without read");

  property p_flag_wrcur;
    @(posedge clock_i) disable iff (rst_i)
      wr_cur |=> flag_q == $past(flag_q);
  endproperty
  a_flag_wrcur: assert property (p_flag_wrcur) else $error("count write touched flag");

  property p_zero_after_hit;
    @(posedge clock_i) disable iff (rst_i)
      hit_zero |=> cnt_q == 24'h000000;
  endproperty
  a_zero_after_hit: assert property (p_zero_after_hit) else $error("count not zero after event");

  // Tick request is a lone pulse, only with its enable set
  property p_tick_off;
    @(posedge clock_i) disable iff (rst_i)
      !hit_zero |=> !tick_req_o;
  endproperty
  a_tick_off: assert property (p_tick_off) else $error("tick request without event");

  property p_tick_pulse;
    @(posedge clock_i) disable iff (rst_i)
      tick_req_o |=> !tick_req_o;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick request longer than a cycle");

  property p_tick_masked;
    @(posedge clock_i) disable iff (rst_i)
      !ctrl_q[`STK_CTRL_TICKIE_BIT] |=> !tick_req_o;
  endproperty
  a_tick_masked: assert property (p_tick_masked) else $error("tick request while disabled");

  property p_irq_clear;
    @(posedge clock_i) disable iff (rst_i)
      (bus_i.wr && sel_stat && bus_i.wdata[0] && !hit_zero) |=> !irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt stuck after clear");

  property p_irq_mask_off;
    @(posedge clock_i) disable iff (rst_i)
      (bus_i.wr && sel_stat && !bus_i.wdata[1]) |=> !irq_o;
  endproperty
  a_irq_mask_off: assert property (p_irq_mask_off) else $error("interrupt with mask off");

  c_wrap: cover property (@(posedge clock_i) disable iff (rst_i) hit_zero ##2 hit_zero);
  c_stop: cover property (@(posedge clock_i) disable iff (rst_i) en && stopped);
  c_rdstat: cover property (@(posedge clock_i) disable iff (rst_i) bus_i.rd && sel_stat && mask_q);
  c_rdclr: cover property (@(posedge clock_i) disable iff (rst_i) flag_q ##1 (bus_i.rd && sel_ctrl));
  c_irq: cover property (@(posedge clock_i) disable iff (rst_i) irq_o);
endmodule // stk_timer

/* tb/stk_timer_tb.sv */
// Self-checking bench for the tick down-counter
`timescale 1ns/1ns
`include "stk_defines.svh"
module stk_timer_tb;
  import stk_pkg::*;
  logic                 clock_i = 1'b0;
  logic                 rst_i = 1'b1;
  stk_bus_req_t         bus_i = '0;
  logic [31:0]          rdata_o, rnd = 32'hbf05, rl;
  logic                 tick_req_o, irq_o;
  int                   failures = 0, checked = 0, t;
  stk_timer i_stk_timer (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
                         .tick_req_o(tick_req_o), .irq_o(irq_o));
  initial forever #50 clock_i = ~clock_i;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i) bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i) bus_i.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock_i) bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock_i) bus_i.rd <= 1'b0;
    @(negedge clock_i) check(rdata_o, e);
  endtask
  // Bounded wait, a hang would otherwise stall the run
  task automatic wait_tick();
    t = 0;
    while (tick_req_o !== 1'b1 && t < 100) begin
      @(negedge clock_i) t++;
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(`STK_OFF_CTRL, 32'h0);
    rd(`STK_OFF_RELOAD, 32'h0);
    rd(`STK_OFF_CURRENT, 32'h0);
    rd(4'h2, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      rl = (i == 0) ? 32'h4 : {28'h0, rnd[3:0]} + 32'h4;
      wr(`STK_OFF_CTRL, 32'h0);
      wr(`STK_OFF_RELOAD, rl);
      wr(`STK_OFF_CURRENT, rnd);
      wr(`STK_OFF_CTRL, 32'h3);
      wait_tick();
      @(negedge clock_i);
      wait_tick();
      check(t + 1, rl + 1);
      rd(`STK_OFF_CTRL, 32'h00010003);
      rd(`STK_OFF_CTRL, 32'h3);
    end
    wr(`STK_OFF_CTRL, 32'h0);
    wr(`STK_OFF_CURRENT, 32'hffffff);
    rd(`STK_OFF_CURRENT, 32'h0);
    check(irq_o, 1'b0);
    wr(`STK_OFF_IRQ_STAT, 32'h2);
    @(negedge clock_i) check(irq_o, 1'b1);
    wr(`STK_OFF_IRQ_STAT, 32'h3);
    @(negedge clock_i) check(irq_o, 1'b0);
    rd(`STK_OFF_IRQ_STAT, 32'h2);
    wr(`STK_OFF_RELOAD, 32'h0);
    wr(`STK_OFF_CTRL, 32'h3);
    repeat (6) @(negedge clock_i) check(tick_req_o, 1'b0);
    rd(`STK_OFF_CURRENT, 32'h0);
    wr(`STK_OFF_CTRL, 32'h1);
    wr(`STK_OFF_RELOAD, 32'h4);
    repeat (12) @(negedge clock_i) check(tick_req_o, 1'b0);
    rd(`STK_OFF_CTRL, 32'h00010001);
    check(irq_o, 1'b1);
    give_verdict();
  end
endmodule // stk_timer_tb
